// ===== logic/sbic_pkg.sv
package sbic_pkg;
    typedef enum logic [4:0] {
        OP_OTHER, OP_SET, OP_CLR, OP_SKT, OP_SKF, OP_SKIP_TRUE_THEN_CLEAR_OP, OP_AND, OP_OR, OP_XOR,
        OP_MOVC, OP_MOVB, OP_ADD_WITH_CARRY_OP, OP_SUBTRACT_WITH_BORROW_OP, OP_ADDS, OP_LDA, OP_LDHL, OP_BR3,
        OP_CALL3, OP_BRCB, OP_CALLF, OP_TABLE_REFERENCED_OP, OP_SELRB, OP_SELMB, OP_PAIR
    } sbic_op_e;
    typedef enum logic [1:0] {MODE_MEM, MODE_FMEM, MODE_PMEM, MODE_HMEM} sbic_mode_e;
    typedef enum logic [1:0] {GRP_NONE, GRP_A, GRP_B} sbic_grp_e;
    typedef enum logic [1:0] {ST_RUN, ST_SKIP2} sbic_state_e;
    typedef struct packed {
        sbic_op_e op;
        logic [1:0] len;
        sbic_mode_e mode;
        logic [1:0] bitpos;
        logic [7:0] mem;
        logic [7:0] imm;
        logic [13:0] target;
        logic [2:0] pair;
        logic [3:0] bank;
        logic [3:0] mb;
        logic [3:0] h_nib;
        logic [3:0] l_nib;
        logic mem_bit;
        logic alu_carry;
        logic other_skip;
    } sbic_ins_s;
    localparam logic [1:0] LEN_3 = 2'h3;
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [13:0] ABS_MAX = 14'h3f7f;
    localparam logic [7:0] TADDR_MIN = 8'h20;
    localparam logic [7:0] TADDR_MAX = 8'h7f;
    localparam logic [3:0] RB_MAX = 4'h3;
    localparam logic [3:0] MB_TOP = 4'hf;
    localparam logic [3:0] FIX_PAGE = 4'hf;
    localparam logic [3:0] FMEM_LO = 4'hb;
    localparam logic [3:0] FMEM_HI = 4'hf;
    localparam logic [7:0] BSB_ADDR = 8'hc0;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STATUS = 12'h004;
    localparam logic [11:0] A_SKIPS = 12'h008;
    localparam logic [11:0] A_NOPS = 12'h00c;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int ST_CY = 0;
    localparam int ST_SKIP = 1;
    localparam int ST_ERR = 4;
    localparam int ST_ARITH = 5;
    localparam int ST_STATE = 6;
endpackage

// ===== logic/sbic_core.sv
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module sbic_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ins_valid,
    input wire sbic_pkg::sbic_ins_s ins,
    output logic ins_ready,
    output logic exec_valid,
    output logic exec_nop,
    output logic [1:0] pc_adv,
    output logic carry_flag,
    output logic bit_we,
    output logic [11:0] bit_addr,
    output logic [1:0] bit_sel,
    output logic bit_wdata
);
    sbic_pkg::sbic_state_e state_reg;
    sbic_pkg::sbic_grp_e grp_reg;
    sbic_pkg::sbic_grp_e ins_grp;
    logic ctrl_en_reg;
    logic skip_pend_reg;
    logic after_arith_reg;
    logic err_reg;
    logic [31:0] skips_reg;
    logic [31:0] nops_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic ins_ready_reg;
    logic exec_valid_reg;
    logic exec_nop_reg;
    logic [1:0] pc_adv_reg;
    logic carry_reg;
    logic bit_we_reg;
    logic [11:0] bit_addr_reg;
    logic [1:0] bit_sel_reg;
    logic bit_wdata_reg;
    logic acc;
    logic skip3;
    logic suppress;
    logic legal;
    logic dedicated;
    logic effective;
    logic skip_cond;
    logic carry_next;
    logic carry_upd;
    logic wr_bit;
    logic wr_val;
    logic [11:0] ea;
    logic [1:0] eb;
    logic apb_rd;
    logic apb_wr;
    logic [31:0] rd_val;
    logic rd_hit;

    assign acc = ins_valid & ins_ready_reg;
    // a 3-byte victim needs a second cycle to walk past its operand bytes
    assign skip3 = acc & skip_pend_reg & (ins.len == sbic_pkg::LEN_3);

    always_comb begin
        unique case (ins.op)
            sbic_pkg::OP_LDA: ins_grp = sbic_pkg::GRP_A;
            sbic_pkg::OP_LDHL: ins_grp = sbic_pkg::GRP_B;
            default: ins_grp = sbic_pkg::GRP_NONE;
        endcase
    end

    // only a load directly following a same-group load that was neither skipped nor malformed drops out
    assign suppress = ~skip_pend_reg & (ins_grp != sbic_pkg::GRP_NONE) & (ins_grp == grp_reg);

    assign dedicated = (ins.op == sbic_pkg::OP_SKIP_TRUE_THEN_CLEAR_OP) | (ins.op == sbic_pkg::OP_AND) |
                       (ins.op == sbic_pkg::OP_OR) | (ins.op == sbic_pkg::OP_XOR) |
                       (ins.op == sbic_pkg::OP_MOVC) | (ins.op == sbic_pkg::OP_MOVB);

    always_comb begin
        legal = 1'b1;
        if (dedicated && ins.mode == sbic_pkg::MODE_MEM) begin
            legal = 1'b0;
        end
        if (ins.mode == sbic_pkg::MODE_FMEM && ins.mem[7:4] != sbic_pkg::FMEM_LO &&
            ins.mem[7:4] != sbic_pkg::FMEM_HI) begin
            legal = 1'b0;
        end
        if (ins.mode == sbic_pkg::MODE_PMEM && ins.mem != sbic_pkg::BSB_ADDR &&
            !(ins.mem[7:4] == sbic_pkg::FIX_PAGE && ins.mem[1:0] == 2'h0)) begin
            legal = 1'b0;
        end
        unique case (ins.op)
            sbic_pkg::OP_LDA: begin
                if (ins.len == sbic_pkg::LEN_1 && ins.imm[7:4] != 4'h0) begin
                    legal = 1'b0;
                end
            end
            sbic_pkg::OP_BR3, sbic_pkg::OP_CALL3: begin
                if (ins.target > sbic_pkg::ABS_MAX) begin
                    legal = 1'b0;
                end
            end
            sbic_pkg::OP_BRCB: begin
                if (ins.target[13:12] != 2'h0) begin
                    legal = 1'b0;
                end
            end
            sbic_pkg::OP_CALLF: begin
                if (ins.target[13:11] != 3'h0) begin
                    legal = 1'b0;
                end
            end
            sbic_pkg::OP_TABLE_REFERENCED_OP: begin
                if (ins.imm[0] || ins.imm < sbic_pkg::TADDR_MIN ||
                    ins.imm > sbic_pkg::TADDR_MAX) begin
                    legal = 1'b0;
                end
            end
            sbic_pkg::OP_SELRB: begin
                if (ins.bank > sbic_pkg::RB_MAX) begin
                    legal = 1'b0;
                end
            end
            sbic_pkg::OP_SELMB: begin
                if (ins.bank > sbic_pkg::RB_MAX && ins.bank != sbic_pkg::MB_TOP) begin
                    legal = 1'b0;
                end
            end
            default: begin
            end
        endcase
    end

    // a skipped, suppressed or malformed instruction writes no bit, carry or skip; a malformed one still sets the error flag
    assign effective = acc & ~skip_pend_reg & ~suppress & legal;

    always_comb begin
        skip_cond = 1'b0;
        carry_next = carry_reg;
        carry_upd = 1'b0;
        wr_bit = 1'b0;
        wr_val = 1'b0;
        unique case (ins.op)
            sbic_pkg::OP_SET: begin
                wr_bit = 1'b1;
                wr_val = 1'b1;
            end
            sbic_pkg::OP_CLR: wr_bit = 1'b1;
            sbic_pkg::OP_SKT: skip_cond = ins.mem_bit;
            sbic_pkg::OP_SKF: skip_cond = ~ins.mem_bit;
            sbic_pkg::OP_SKIP_TRUE_THEN_CLEAR_OP: begin
                skip_cond = ins.mem_bit;
                wr_bit = ins.mem_bit;
            end
            sbic_pkg::OP_AND: begin
                carry_next = carry_reg & ins.mem_bit;
                carry_upd = 1'b1;
            end
            sbic_pkg::OP_OR: begin
                carry_next = carry_reg | ins.mem_bit;
                carry_upd = 1'b1;
            end
            sbic_pkg::OP_XOR: begin
                carry_next = carry_reg ^ ins.mem_bit;
                carry_upd = 1'b1;
            end
            sbic_pkg::OP_MOVC: begin
                carry_next = ins.mem_bit;
                carry_upd = 1'b1;
            end
            sbic_pkg::OP_MOVB: begin
                wr_bit = 1'b1;
                wr_val = carry_reg;
            end
            sbic_pkg::OP_ADD_WITH_CARRY_OP: begin
                skip_cond = ins.alu_carry;
                carry_next = ins.alu_carry;
                carry_upd = 1'b1;
            end
            sbic_pkg::OP_SUBTRACT_WITH_BORROW_OP: begin
                skip_cond = ~ins.alu_carry;
                carry_next = ins.alu_carry;
                carry_upd = 1'b1;
            end
            sbic_pkg::OP_ADDS: skip_cond = ins.alu_carry & ~after_arith_reg;
            sbic_pkg::OP_OTHER, sbic_pkg::OP_TABLE_REFERENCED_OP: skip_cond = ins.other_skip;
            default: begin
            end
        endcase
    end

    // ports live in the top page, so port bits are plain memory addresses
    always_comb begin
        eb = ins.bitpos;
        unique case (ins.mode)
            sbic_pkg::MODE_FMEM: ea = {sbic_pkg::FIX_PAGE, ins.mem};
            sbic_pkg::MODE_PMEM: begin
                ea = {sbic_pkg::FIX_PAGE, ins.mem[7:2], ins.l_nib[3:2]};
                eb = ins.l_nib[1:0];
            end
            sbic_pkg::MODE_HMEM: ea = {ins.mb, ins.h_nib, ins.mem[3:0]};
            default: ea = {ins.mb, ins.mem};
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= sbic_pkg::ST_RUN;
            ins_ready_reg <= 1'b0;
        end else begin
            state_reg <= skip3 ? sbic_pkg::ST_SKIP2 : sbic_pkg::ST_RUN;
            ins_ready_reg <= ctrl_en_reg & ~skip3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_pend_reg <= 1'b0;
            after_arith_reg <= 1'b0;
            grp_reg <= sbic_pkg::GRP_NONE;
        end else if (acc) begin
            // the skip covers exactly one instruction, then clears
            skip_pend_reg <= effective & skip_cond;
            after_arith_reg <= effective &
                ((ins.op == sbic_pkg::OP_ADD_WITH_CARRY_OP) | (ins.op == sbic_pkg::OP_SUBTRACT_WITH_BORROW_OP));
            if (skip_pend_reg || !legal) begin
                grp_reg <= sbic_pkg::GRP_NONE;
            end else if (!suppress) begin
                grp_reg <= ins_grp;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_valid_reg <= 1'b0;
            exec_nop_reg <= 1'b0;
            pc_adv_reg <= 2'h0;
            carry_reg <= 1'b0;
        end else begin
            exec_valid_reg <= acc;
            exec_nop_reg <= acc & ~effective;
            pc_adv_reg <= acc ? ins.len : 2'h0;
            if (effective && carry_upd) begin
                carry_reg <= carry_next;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_we_reg <= 1'b0;
            bit_addr_reg <= 12'h000;
            bit_sel_reg <= 2'h0;
            bit_wdata_reg <= 1'b0;
        end else begin
            bit_we_reg <= effective & wr_bit;
            if (effective && wr_bit) begin
                bit_addr_reg <= ea;
                bit_sel_reg <= eb;
                bit_wdata_reg <= wr_val;
            end
        end
    end

    // one count per machine cycle spent on skipping, one clock each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skips_reg <= 32'h0;
            nops_reg <= 32'h0;
        end else begin
            if ((acc && skip_pend_reg) || state_reg == sbic_pkg::ST_SKIP2) begin
                skips_reg <= skips_reg + 32'h1;
            end
            if (acc && !effective) begin
                nops_reg <= nops_reg + 32'h1;
            end
        end
    end

    // apb: one wait state, write lands on the edge that sees pready
    assign apb_rd = psel & penable & ~pready_reg;
    assign apb_wr = psel & penable & pready_reg & pwrite;

    always_comb begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        unique case (paddr)
            sbic_pkg::A_CTRL: rd_val[0] = ctrl_en_reg;
            sbic_pkg::A_STATUS: begin
                rd_val[sbic_pkg::ST_CY] = carry_reg;
                rd_val[sbic_pkg::ST_SKIP] = skip_pend_reg;
                rd_val[3:2] = grp_reg;
                rd_val[sbic_pkg::ST_ERR] = err_reg;
                rd_val[sbic_pkg::ST_ARITH] = after_arith_reg;
                rd_val[sbic_pkg::ST_STATE] = (state_reg == sbic_pkg::ST_SKIP2);
            end
            sbic_pkg::A_SKIPS: rd_val = skips_reg;
            sbic_pkg::A_NOPS: rd_val = nops_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= apb_rd;
            pslverr_reg <= apb_rd & ~rd_hit;
            prdata_reg <= (apb_rd && !pwrite) ? rd_val : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_reg <= sbic_pkg::CTRL_EN_RST;
            err_reg <= 1'b0;
        end else begin
            if (apb_wr && paddr == sbic_pkg::A_CTRL) begin
                ctrl_en_reg <= pwdata[0];
            end
            // a fresh error beats a simultaneous clear
            if (acc && !legal) begin
                err_reg <= 1'b1;
            end else if (apb_wr && paddr == sbic_pkg::A_STATUS && pwdata[sbic_pkg::ST_ERR]) begin
                err_reg <= 1'b0;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign ins_ready = ins_ready_reg;
    assign exec_valid = exec_valid_reg;
    assign exec_nop = exec_nop_reg;
    assign pc_adv = pc_adv_reg;
    assign carry_flag = carry_reg;
    assign bit_we = bit_we_reg;
    assign bit_addr = bit_addr_reg;
    assign bit_sel = bit_sel_reg;
    assign bit_wdata = bit_wdata_reg;

    property p_suppress;
        @(posedge pclk) disable iff (!presetn)
        acc && !skip_pend_reg && legal && ins_grp != sbic_pkg::GRP_NONE && ins_grp == grp_reg
        |=> exec_nop_reg && !bit_we_reg;
    endproperty
    a_suppress: assert property (p_suppress) else $error("same group load not suppressed");

    property p_skip3;
        @(posedge pclk) disable iff (!presetn)
        skip3 && ctrl_en_reg |=> !ins_ready_reg ##1 ins_ready_reg;
    endproperty
    a_skip3: assert property (p_skip3) else $error("3-byte skip not two cycles");

    property p_skip1;
        @(posedge pclk) disable iff (!presetn)
        acc && skip_pend_reg && ins.len != sbic_pkg::LEN_3 && ctrl_en_reg |=> ins_ready_reg;
    endproperty
    a_skip1: assert property (p_skip1) else $error("short skip took extra cycle");

    property p_adds;
        @(posedge pclk) disable iff (!presetn)
        acc && ins.op == sbic_pkg::OP_ADDS && after_arith_reg |=> !skip_pend_reg;
    endproperty
    a_adds: assert property (p_adds) else $error("add-skip after arithmetic skipped");

    property p_add_with_carry_op;
        @(posedge pclk) disable iff (!presetn)
        effective && ins.op == sbic_pkg::OP_ADD_WITH_CARRY_OP && ins.alu_carry
        |=> skip_pend_reg && carry_reg;
    endproperty
    a_add_with_carry_op: assert property (p_add_with_carry_op) else $error("carry did not arm skip");

    property p_subtract_with_borrow_op;
        @(posedge pclk) disable iff (!presetn)
        effective && ins.op == sbic_pkg::OP_SUBTRACT_WITH_BORROW_OP |=> skip_pend_reg == !carry_reg;
    endproperty
    a_subtract_with_borrow_op: assert property (p_subtract_with_borrow_op) else $error("borrow skip mismatch");

    property p_subcy;
        @(posedge pclk) disable iff (!presetn)
        effective && ins.op == sbic_pkg::OP_SUBTRACT_WITH_BORROW_OP |=> carry_reg == $past(ins.alu_carry);
    endproperty
    a_subcy: assert property (p_subcy) else $error("underflow not in carry");

    property p_quiet;
        @(posedge pclk) disable iff (!presetn)
        acc && skip_pend_reg |=> !bit_we_reg && $stable(carry_reg) && exec_nop_reg;
    endproperty
    a_quiet: assert property (p_quiet) else $error("skipped op changed state");

    property p_mode;
        @(posedge pclk) disable iff (!presetn)
        acc && dedicated && ins.mode == sbic_pkg::MODE_MEM |=> exec_nop_reg ##1 err_reg;
    endproperty
    a_mode: assert property (p_mode) else $error("plain mode accepted");

    property p_once;
        @(posedge pclk) disable iff (!presetn)
        acc && skip_pend_reg |=> !skip_pend_reg;
    endproperty
    a_once: assert property (p_once) else $error("skip covered more than one op");
endmodule

// ===== verif/sbic_mem_model.sv
`timescale 1ns/1ps
module sbic_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ins_ready,
    input wire logic bit_we,
    input wire logic [11:0] bit_addr,
    input wire logic [1:0] bit_sel,
    input wire logic bit_wdata,
    input wire logic slow,
    output logic ins_valid,
    output sbic_pkg::sbic_ins_s ins
);
    sbic_pkg::sbic_ins_s prog[$];
    logic [3:0] dmem [0:4095];
    // idle bus shows inverted garbage so a stale opcode is never mistaken for a fetch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ins_valid <= 1'b0;
            ins <= '0;
        end else if (!ins_valid || ins_ready) begin
            if (prog.size() > 0 && !(slow && $urandom_range(1, 0) == 1)) begin
                ins <= prog.pop_front();
                ins_valid <= 1'b1;
            end else begin
                ins <= sbic_pkg::sbic_ins_s'(~ins);
                ins_valid <= 1'b0;
            end
        end
    end
    always @(posedge pclk) begin
        if (bit_we) begin
            dmem[bit_addr][bit_sel] <= bit_wdata;
        end
    end
endmodule

// ===== verif/skip_and_bit_instruction_control_tb_top.sv
`timescale 1ns/1ps
module skip_and_bit_instruction_control_tb_top;
    typedef struct packed {
        logic nop;
        logic [1:0] adv;
        logic cy;
        logic we;
        logic [11:0] a;
        logic [1:0] s;
        logic wd;
    } sbic_exp_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic slow = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, ins_valid, ins_ready, exec_valid, exec_nop, carry_flag;
    logic bit_we, bit_wdata;
    logic [1:0] pc_adv, bit_sel;
    logic [11:0] bit_addr;
    sbic_pkg::sbic_ins_s ins;
    int mismatches = 0;
    int n_tests = 0;
    sbic_exp_s expq[$];
    sbic_exp_s got;
    logic cy_m = 1'b0;
    sbic_pkg::sbic_op_e rops [4] = '{sbic_pkg::OP_AND, sbic_pkg::OP_OR, sbic_pkg::OP_XOR,
        sbic_pkg::OP_MOVC};

    always #12.5 pclk = ~pclk;

    sbic_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ins_valid(ins_valid), .ins(ins), .ins_ready(ins_ready),
        .exec_valid(exec_valid), .exec_nop(exec_nop), .pc_adv(pc_adv),
        .carry_flag(carry_flag), .bit_we(bit_we), .bit_addr(bit_addr), .bit_sel(bit_sel),
        .bit_wdata(bit_wdata));
    sbic_mem_model pm (.pclk(pclk), .presetn(presetn), .ins_ready(ins_ready),
        .bit_we(bit_we), .bit_addr(bit_addr), .bit_sel(bit_sel), .bit_wdata(bit_wdata),
        .slow(slow), .ins_valid(ins_valid), .ins(ins));

    task check(input string n, input logic [31:0] seen, input logic [31:0] x);
        n_tests++;
        if (seen !== x) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, x, seen);
        end
    endtask

    task final_report;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input string n, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, '0);
        check(n, rd, x);
    endtask

    function automatic logic [11:0] baddr(sbic_pkg::sbic_ins_s i);
        case (i.mode)
            sbic_pkg::MODE_FMEM: return {sbic_pkg::FIX_PAGE, i.mem};
            sbic_pkg::MODE_PMEM: return {4'hf, i.mem[7:2], i.l_nib[3:2]};
            sbic_pkg::MODE_HMEM: return {i.mb, i.h_nib, i.mem[3:0]};
            default: return {i.mb, i.mem};
        endcase
    endfunction

    function automatic sbic_pkg::sbic_ins_s mk(sbic_pkg::sbic_op_e op, logic [1:0] len);
        sbic_pkg::sbic_ins_s i;
        i = '0;
        i.op = op;
        i.len = len;
        i.mode = sbic_pkg::MODE_FMEM;
        i.mem = 8'hb0;
        return i;
    endfunction

    // queue one instruction with its expected outcome; skip decisions come from the caller
    task automatic put(input sbic_pkg::sbic_ins_s i, input logic nop);
        sbic_exp_s e;
        e = '0;
        e.nop = nop;
        e.adv = i.len;
        e.a = baddr(i);
        e.s = (i.mode == sbic_pkg::MODE_PMEM) ? i.l_nib[1:0] : i.bitpos;
        if (!nop) begin
            case (i.op)
                sbic_pkg::OP_ADD_WITH_CARRY_OP, sbic_pkg::OP_SUBTRACT_WITH_BORROW_OP: cy_m = i.alu_carry;
                sbic_pkg::OP_AND: cy_m = cy_m & i.mem_bit;
                sbic_pkg::OP_OR: cy_m = cy_m | i.mem_bit;
                sbic_pkg::OP_XOR: cy_m = cy_m ^ i.mem_bit;
                sbic_pkg::OP_MOVC: cy_m = i.mem_bit;
                sbic_pkg::OP_SET, sbic_pkg::OP_CLR: begin
                    e.we = 1'b1;
                    e.wd = (i.op == sbic_pkg::OP_SET);
                end
                sbic_pkg::OP_MOVB: begin
                    e.we = 1'b1;
                    e.wd = cy_m;
                end
                sbic_pkg::OP_SKIP_TRUE_THEN_CLEAR_OP: e.we = i.mem_bit;
                default: e.we = 1'b0;
            endcase
        end
        e.cy = cy_m;
        pm.prog.push_back(i);
        expq.push_back(e);
    endtask

    task op1(input sbic_pkg::sbic_op_e op, input logic c, input logic nop);
        sbic_pkg::sbic_ins_s i;
        i = mk(op, sbic_pkg::LEN_1);
        i.alu_carry = c;
        i.mem_bit = c;
        put(i, nop);
    endtask

    task drain;
        int k;
        k = 0;
        while ((expq.size() > 0 || pm.prog.size() > 0) && k < 400) begin
            @(posedge pclk);
            k++;
        end
        check("drain", k < 400, 1);
        repeat (2) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (presetn && exec_valid === 1'b1) begin
            got = expq.pop_front();
            check("exec", {exec_nop, pc_adv, carry_flag, bit_we},
                {got.nop, got.adv, got.cy, got.we});
            if (got.we) begin
                check("bitw", {bit_addr, bit_sel, bit_wdata}, {got.a, got.s, got.wd});
            end
        end
    end

    initial begin
        #100us;
        mismatches++;
        $display("MISMATCH watchdog expected finish seen timeout");
        final_report();
    end

    initial begin
        sbic_pkg::sbic_ins_s i;
        void'($urandom(85994));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h010, '0);
        check("unmapped", {er, rd}, {1'b1, 32'h0});
        @(negedge pclk);
        op1(sbic_pkg::OP_ADD_WITH_CARRY_OP, 1, 0);
        op1(sbic_pkg::OP_ADDS, 0, 1);
        op1(sbic_pkg::OP_OTHER, 0, 0);
        op1(sbic_pkg::OP_ADD_WITH_CARRY_OP, 0, 0);
        op1(sbic_pkg::OP_ADDS, 1, 0);
        op1(sbic_pkg::OP_OTHER, 0, 0);
        op1(sbic_pkg::OP_SUBTRACT_WITH_BORROW_OP, 0, 0);
        op1(sbic_pkg::OP_ADDS, 0, 1);
        op1(sbic_pkg::OP_SUBTRACT_WITH_BORROW_OP, 1, 0);
        op1(sbic_pkg::OP_ADDS, 1, 0);
        op1(sbic_pkg::OP_OTHER, 0, 0);
        drain();
        rdchk("skips", sbic_pkg::A_SKIPS, 2);
        @(negedge pclk);
        op1(sbic_pkg::OP_SKT, 1, 0);
        i = mk(sbic_pkg::OP_BR3, sbic_pkg::LEN_3);
        i.target = 14'h0100;
        put(i, 1);
        op1(sbic_pkg::OP_SKF, 0, 0);
        i = mk(sbic_pkg::OP_TABLE_REFERENCED_OP, sbic_pkg::LEN_1);
        i.mem = 8'h20;
        put(i, 1);
        i = mk(sbic_pkg::OP_SKIP_TRUE_THEN_CLEAR_OP, sbic_pkg::LEN_1);
        i.mem = 8'hf3;
        i.bitpos = 2'h2;
        i.mem_bit = 1'b1;
        put(i, 0);
        op1(sbic_pkg::OP_SET, 0, 1);
        op1(sbic_pkg::OP_SKT, 0, 0);
        op1(sbic_pkg::OP_OTHER, 0, 0);
        op1(sbic_pkg::OP_SKT, 1, 0);
        i = mk(sbic_pkg::OP_LDA, sbic_pkg::LEN_1);
        i.imm = 8'h05;
        put(i, 1);
        put(i, 0);
        put(i, 1);
        i = mk(sbic_pkg::OP_LDHL, 2'h2);
        put(i, 0);
        put(i, 1);
        i = mk(sbic_pkg::OP_LDA, 2'h2);
        put(i, 0);
        op1(sbic_pkg::OP_OTHER, 0, 0);
        drain();
        rdchk("skips", sbic_pkg::A_SKIPS, 7);
        rdchk("nops", sbic_pkg::A_NOPS, 8);
        @(negedge pclk);
        i = mk(sbic_pkg::OP_SET, sbic_pkg::LEN_1);
        i.mem = 8'hb2;
        i.bitpos = 2'h3;
        put(i, 0);
        i.op = sbic_pkg::OP_CLR;
        i.mode = sbic_pkg::MODE_PMEM;
        i.mem = 8'hf4;
        i.l_nib = 4'hb;
        put(i, 0);
        i.mem = sbic_pkg::BSB_ADDR;
        put(i, 0);
        i.mode = sbic_pkg::MODE_HMEM;
        i.mb = 4'h2;
        i.h_nib = 4'h5;
        i.mem = 8'h07;
        put(i, 0);
        i.mode = sbic_pkg::MODE_MEM;
        i.mb = 4'h1;
        i.mem = 8'h44;
        put(i, 0);
        // load carry without arming a skip over the bit move
        op1(sbic_pkg::OP_MOVC, 1, 0);
        i = mk(sbic_pkg::OP_MOVB, sbic_pkg::LEN_1);
        i.mem = 8'hff;
        i.bitpos = 2'h1;
        put(i, 0);
        i = mk(sbic_pkg::OP_AND, sbic_pkg::LEN_1);
        i.mode = sbic_pkg::MODE_MEM;
        put(i, 1);
        i.mode = sbic_pkg::MODE_FMEM;
        i.mem = 8'ha0;
        put(i, 1);
        i.mode = sbic_pkg::MODE_PMEM;
        i.mem = 8'hf1;
        put(i, 1);
        i.mem = 8'hf8;
        i.mem_bit = 1'b1;
        put(i, 0);
        i = mk(sbic_pkg::OP_BR3, sbic_pkg::LEN_3);
        i.target = 14'h3f80;
        put(i, 1);
        i.target = sbic_pkg::ABS_MAX;
        put(i, 0);
        i = mk(sbic_pkg::OP_BRCB, 2'h2);
        i.target = 14'h1000;
        put(i, 1);
        i.target = 14'h0fff;
        put(i, 0);
        i.op = sbic_pkg::OP_CALLF;
        i.target = 14'h0800;
        put(i, 1);
        i.target = 14'h07ff;
        put(i, 0);
        i = mk(sbic_pkg::OP_TABLE_REFERENCED_OP, sbic_pkg::LEN_1);
        foreach (rops[n]) begin
            i.imm = (n == 0) ? 8'h21 : (n == 1) ? 8'h80 : (n == 2) ? 8'h1e : 8'h7e;
            put(i, n != 3);
        end
        i = mk(sbic_pkg::OP_SELRB, 2'h2);
        i.bank = 4'h4;
        put(i, 1);
        i.bank = sbic_pkg::RB_MAX;
        put(i, 0);
        i.op = sbic_pkg::OP_SELMB;
        i.bank = 4'h4;
        put(i, 1);
        i.bank = sbic_pkg::MB_TOP;
        put(i, 0);
        i = mk(sbic_pkg::OP_LDA, sbic_pkg::LEN_1);
        i.imm = 8'h10;
        put(i, 1);
        op1(sbic_pkg::OP_OTHER, 0, 0);
        i = mk(sbic_pkg::OP_PAIR, 2'h2);
        i.pair = 3'h7;
        put(i, 0);
        drain();
        check("dmem", pm.dmem[12'hfff][1], 1);
        apb(1'b0, sbic_pkg::A_STATUS, '0);
        check("err", rd[sbic_pkg::ST_ERR], 1);
        apb(1'b1, sbic_pkg::A_STATUS, 32'h10);
        rdchk("err_clr", sbic_pkg::A_STATUS, {31'h0, cy_m});
        // stalls only here: carry ops carry no state that a gap could break
        slow = 1'b1;
        @(negedge pclk);
        repeat (24) begin
            i = mk(rops[$urandom_range(3, 0)], sbic_pkg::LEN_1);
            i.mem = {($urandom_range(1, 0) == 1) ? 4'hf : 4'hb, 4'($urandom)};
            i.bitpos = 2'($urandom);
            i.mem_bit = 1'($urandom);
            put(i, 0);
        end
        drain();
        final_report();
    end
endmodule
